/* rtl/frwls_top.sv */
// Flash row write-latch sequencer with its Avalon-MM register slave.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "frwls_defines.svh"
// Operation
// - programming a row never erases first
// - erase works on exactly one row
// - 32 latches, one row per program
// - upper ten bits row, low five latch
// - programming never leaves the selected row
// - latches blank after row programming
// - latches blank after erase too
// - latch-only mode loads latch, no array access
// - latch-only clear loads latch then programs row
// - latch load and program need unlock
// - region select maps the auxiliary space
// - invalid auxiliary read returns zeros
// - only user IDs writable in auxiliary space
// - any word count up to 32
// - write error on protection, single-cycle reset, abort
// - completion sets done flag, optional request
module frwls_top
  import frwls_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Avalon-MM register slave.
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Flash array port.
  output frwls_fa_req_t    fa_req_o,
  input  wire logic        fa_ack_i,
  input  wire logic [13:0] fa_rdata_i,
  // Completion request.
  output logic             irq_o
);
  frwls_state_t  state_reg;
  frwls_state_t  state_next;
  frwls_unlock_t unlock_reg;
  frwls_unlock_t unlock_next;
  frwls_fa_req_t fa_req_reg;
  frwls_fa_req_t fa_req_next;
  logic [4:0]    idx_reg;
  logic [4:0]    idx_next;
  logic [15:0]   op_addr_reg;
  logic [15:0]   op_addr_next;
  logic [7:0]    adr_lo_reg;
  logic [6:0]    adr_hi_reg;
  logic [7:0]    dat_lo_reg;
  logic [7:0]    dat_lo_next;
  logic [5:0]    dat_hi_reg;
  logic [5:0]    dat_hi_next;
  logic          write_enable_bit_reg;
  logic          latch_only_mode_reg;
  logic          free_reg;
  logic          regs_reg;
  logic          err_reg;
  logic          err_next;
  logic          done_reg;
  logic          done_next;
  logic          ie_reg;
  logic          ie_next;
  logic          irq_reg;
  logic          waitreq_reg;
  logic [31:0]   rdata_reg;
  // Bus decode.
  logic        bus_req;
  logic        bus_acc;
  logic        any_wr;
  logic        wr_acc;
  logic [7:0]  wd;
  logic        wr_ctrl;
  logic        wr_unlock;
  logic        wr_adr_lo;
  logic        wr_adr_hi;
  logic        wr_dat_lo;
  logic        wr_dat_hi;
  logic        wr_ctrl_b;
  logic [7:0]  rd_mux;
  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_acc   = bus_req & ~waitreq_reg;
  assign any_wr    = bus_acc & avs_write_i;
  assign wr_acc    = any_wr & avs_byteenable_i[0];
  assign wd        = avs_writedata_i[7:0];
  assign wr_ctrl   = wr_acc && avs_address_i == `FRWLS_OFS_CTRL_A;
  assign wr_unlock = wr_acc && avs_address_i == `FRWLS_OFS_UNLOCK;
  assign wr_adr_lo = wr_acc && avs_address_i == `FRWLS_OFS_ADR_LO;
  assign wr_adr_hi = wr_acc && avs_address_i == `FRWLS_OFS_ADR_HI;
  assign wr_dat_lo = wr_acc && avs_address_i == `FRWLS_OFS_DAT_LO;
  assign wr_dat_hi = wr_acc && avs_address_i == `FRWLS_OFS_DAT_HI;
  assign wr_ctrl_b = wr_acc && avs_address_i == `FRWLS_OFS_CTRL_B;
  // Operation decode.
  logic [14:0] cur_addr;
  logic        rd_ok;
  logic        wr_ok;
  logic        go_wr;
  logic        go_ok;
  logic        go_rd;
  logic        wp_hit;
  logic        abort;
  logic        rd_pend;
  logic        wr_pend;
  logic        self_write;
  logic        lat_load;
  logic [13:0] lat_data;
  assign cur_addr   = {adr_hi_reg, adr_lo_reg};
  assign go_wr      = wr_ctrl && wd[`FRWLS_BIT_WR] && wd[`FRWLS_BIT_WRITE_ENABLE_BIT]
                   && unlock_reg == UL_KEY2 && state_reg == ST_IDLE;
  assign wp_hit     = go_wr && (wd[`FRWLS_BIT_FREE] || !wd[`FRWLS_BIT_LATCH_ONLY_MODE]) && !wr_ok;
  assign go_ok      = go_wr && !wp_hit;
  assign go_rd      = wr_ctrl && wd[`FRWLS_BIT_RD] && !go_wr && state_reg == ST_IDLE;
  assign abort      = any_wr && unlock_reg != UL_IDLE
                   && !(wr_unlock && unlock_reg == UL_KEY1 && wd == `FRWLS_KEY2)
                   && !(wr_ctrl && wd[`FRWLS_BIT_WR] && unlock_reg == UL_KEY2);
  assign rd_pend    = state_reg == ST_READ;
  assign wr_pend    = state_reg inside {ST_LOAD, ST_ERASE, ST_PROG, ST_BLANK};
  assign self_write = state_reg inside {ST_ERASE, ST_PROG};
  assign lat_load   = go_ok && !wd[`FRWLS_BIT_FREE];
  assign lat_data   = {dat_hi_reg, dat_lo_reg};
  frwls_region_check u_region (
    .aux_i   (wd[`FRWLS_BIT_REGS]),
    .addr_i  (cur_addr),
    .rd_ok_o (rd_ok),
    .wr_ok_o (wr_ok)
  );
  logic [13:0] lat_rd;
  frwls_latch_bank u_latch (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .load_i      (lat_load),
    .load_idx_i  (cur_addr[4:0]),
    .load_data_i (lat_data),
    .blank_i     (state_reg == ST_BLANK),
    .rd_idx_i    (idx_next),
    .rd_data_o   (lat_rd)
  );
  assign unlock_next = !any_wr ? unlock_reg :
                       (wr_unlock && wd == `FRWLS_KEY1 && unlock_reg == UL_IDLE) ? UL_KEY1 :
                       (wr_unlock && wd == `FRWLS_KEY2 && unlock_reg == UL_KEY1) ? UL_KEY2 :
                       UL_IDLE;

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // erase path takes the whole row
        if (go_ok) begin
          state_next = wd[`FRWLS_BIT_FREE] ? ST_ERASE : ST_LOAD;
        end else if (go_rd && rd_ok) begin
          state_next = ST_READ;
        end
      end
      ST_LOAD: begin
        state_next = latch_only_mode_reg ? ST_IDLE : ST_PROG;
        idx_next   = 5'h00;
      end
      ST_READ: begin
        if (fa_ack_i) begin
          state_next = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (fa_ack_i) begin
          state_next = ST_BLANK;
        end
      end
      ST_PROG: begin
        // at most one word per latch
        if (fa_ack_i && idx_reg == `FRWLS_LAST_IDX) begin
          state_next = ST_BLANK;
        end else if (fa_ack_i) begin
          idx_next = idx_reg + 5'h01;
        end
      end
      ST_BLANK: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // region bit forms address bit 15
  assign op_addr_next = (go_ok || go_rd) ? {wd[`FRWLS_BIT_REGS], cur_addr} : op_addr_reg;
  // row held from start, latch index walks
  assign fa_req_next.valid = state_next inside {ST_READ, ST_ERASE, ST_PROG};
  assign fa_req_next.cmd   = state_next == ST_READ  ? FA_READ  :
                             state_next == ST_ERASE ? FA_ERASE :
                             state_next == ST_PROG  ? FA_PROG  : FA_NONE;
  assign fa_req_next.addr  = state_next == ST_READ  ? op_addr_next :
                             state_next == ST_PROG  ? {op_addr_next[15:5], idx_next} :
                             {op_addr_next[15:5], 5'h00};
  assign fa_req_next.wdata = state_next == ST_PROG ? lat_rd : `FRWLS_BLANK;

  assign dat_lo_next = (go_rd && !rd_ok) ? 8'h00 :
                       (rd_pend && fa_ack_i) ? fa_rdata_i[7:0] :
                       wr_dat_lo ? wd : dat_lo_reg;
  assign dat_hi_next = (go_rd && !rd_ok) ? 6'h00 :
                       (rd_pend && fa_ack_i) ? fa_rdata_i[13:8] :
                       wr_dat_hi ? wd[5:0] : dat_hi_reg;
  assign err_next  = abort || wp_hit || (wr_ctrl ? wd[`FRWLS_BIT_ERR] : err_reg);
  // completion flag, cleared by writing zero
  assign done_next = state_reg == ST_BLANK
                  || (wr_ctrl_b ? done_reg && wd[`FRWLS_BIT_DONE] : done_reg);
  assign ie_next   = wr_ctrl_b ? wd[`FRWLS_BIT_IE] : ie_reg;

  always_comb begin
    unique case (avs_address_i)
      `FRWLS_OFS_CTRL_A: rd_mux = {1'b0, regs_reg, free_reg, latch_only_mode_reg,
                                   err_reg, write_enable_bit_reg, wr_pend, rd_pend};
      `FRWLS_OFS_ADR_LO: rd_mux = adr_lo_reg;
      `FRWLS_OFS_ADR_HI: rd_mux = {1'b0, adr_hi_reg};
      `FRWLS_OFS_DAT_LO: rd_mux = dat_lo_reg;
      `FRWLS_OFS_DAT_HI: rd_mux = {2'b00, dat_hi_reg};
      `FRWLS_OFS_CTRL_B: rd_mux = {6'h00, ie_reg, done_reg};
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      waitreq_reg <= ~(bus_req & waitreq_reg);
      if (avs_read_i && waitreq_reg) begin
        rdata_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_reg   <= ST_IDLE;
      unlock_reg  <= UL_IDLE;
      idx_reg     <= 5'h00;
      op_addr_reg <= 16'h0000;
      fa_req_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      unlock_reg  <= unlock_next;
      idx_reg     <= idx_next;
      op_addr_reg <= op_addr_next;
      fa_req_reg  <= fa_req_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      adr_lo_reg <= 8'h00;
      adr_hi_reg <= 7'h00;
      dat_lo_reg <= 8'h00;
      dat_hi_reg <= 6'h00;
    end else begin
      adr_lo_reg <= wr_adr_lo ? wd : adr_lo_reg;
      adr_hi_reg <= wr_adr_hi ? wd[6:0] : adr_hi_reg;
      dat_lo_reg <= dat_lo_next;
      dat_hi_reg <= dat_hi_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      // a single-cycle reset during a self-write is flagged; a longer reset clears the flag again
      err_reg  <= self_write;
      write_enable_bit_reg <= 1'b0;
      latch_only_mode_reg <= 1'b0;
      free_reg <= 1'b0;
      regs_reg <= 1'b0;
      done_reg <= 1'b0;
      ie_reg   <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      err_reg  <= err_next;
      write_enable_bit_reg <= wr_ctrl ? wd[`FRWLS_BIT_WRITE_ENABLE_BIT] : write_enable_bit_reg;
      latch_only_mode_reg <= wr_ctrl ? wd[`FRWLS_BIT_LATCH_ONLY_MODE] : latch_only_mode_reg;
      free_reg <= wr_ctrl ? wd[`FRWLS_BIT_FREE] : free_reg;
      regs_reg <= wr_ctrl ? wd[`FRWLS_BIT_REGS] : regs_reg;
      done_reg <= done_next;
      ie_reg   <= ie_next;
      irq_reg  <= done_next & ie_next;
    end
  end

  assign avs_waitrequest_o = waitreq_reg;
  assign avs_readdata_o    = rdata_reg;
  assign fa_req_o          = fa_req_reg;
  assign irq_o             = irq_reg;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_PROG_NO_ERASE: assert property (state_reg == ST_PROG |->
    fa_req_o.valid && fa_req_o.cmd == FA_PROG) else $error("program issued other command");
  AST_ERASE_ROW: assert property (fa_req_o.cmd == FA_ERASE |->
    fa_req_o.valid && fa_req_o.addr[4:0] == 5'h00) else $error("erase not one row");
  AST_ERASE_END: assert property (state_reg == ST_ERASE && fa_ack_i |=>
    state_reg == ST_BLANK) else $error("erase did not close");
  AST_LAST_WORD: assert property (state_reg == ST_PROG && fa_ack_i
    && idx_reg == 5'h1f |=> state_reg == ST_BLANK) else $error("row not closed at 32");
  AST_ROW_STAY: assert property (state_reg == ST_PROG |->
    fa_req_o.addr == {op_addr_reg[15:5], idx_reg}) else $error("program left row");
  AST_LATCH_ONLY: assert property (go_ok && !wd[`FRWLS_BIT_FREE]
    && wd[`FRWLS_BIT_LATCH_ONLY_MODE] |=> state_reg == ST_LOAD ##1 state_reg == ST_IDLE
    && !fa_req_o.valid) else $error("latch-only touched array");
  AST_PROG_START: assert property (go_ok && !wd[`FRWLS_BIT_FREE]
    && !wd[`FRWLS_BIT_LATCH_ONLY_MODE] |=> ##1 fa_req_o.cmd == FA_PROG
    && fa_req_o.addr[4:0] == 5'h00) else $error("program did not start");
  AST_UNLOCK: assert property ($rose(wr_pend) |-> $past(unlock_reg) == UL_KEY2)
    else $error("work began without unlock");
  AST_AUX_ZERO: assert property (go_rd && !rd_ok |=> dat_lo_reg == 8'h00
    && dat_hi_reg == 6'h00 && state_reg == ST_IDLE) else $error("bad read not zero");
  AST_WP: assert property (wp_hit |=> err_reg && state_reg == ST_IDLE
    && !wr_pend) else $error("protected write not refused");
  AST_ABORT_ERR: assert property (abort |=> err_reg && unlock_reg == UL_IDLE)
    else $error("interrupted unlock not flagged");
  AST_DONE: assert property (state_reg == ST_BLANK |=> done_reg
    && irq_o == ie_reg && state_reg == ST_IDLE) else $error("completion not flagged");
  COV_FULL_ROW: cover property (state_reg == ST_PROG && idx_reg == 5'h1f && fa_ack_i);
  COV_ERASE: cover property (state_reg == ST_ERASE && fa_ack_i);
  COV_AUX_ZERO: cover property (go_rd && !rd_ok);
  COV_ABORT: cover property (abort);
endmodule

/* rtl/frwls_defines.svh */
// Offsets, field positions, blank value and address ranges of the sequencer.
`ifndef FRWLS_DEFINES_SVH
`define FRWLS_DEFINES_SVH
`define FRWLS_OFS_CTRL_A  5'h00
`define FRWLS_OFS_UNLOCK  5'h04
`define FRWLS_OFS_ADR_LO  5'h08
`define FRWLS_OFS_ADR_HI  5'h0c
`define FRWLS_OFS_DAT_LO  5'h10
`define FRWLS_OFS_DAT_HI  5'h14
`define FRWLS_OFS_CTRL_B  5'h18
`define FRWLS_BIT_RD      0
`define FRWLS_BIT_WR      1
`define FRWLS_BIT_WRITE_ENABLE_BIT    2
`define FRWLS_BIT_ERR     3
`define FRWLS_BIT_LATCH_ONLY_MODE    4
`define FRWLS_BIT_FREE    5
`define FRWLS_BIT_REGS    6
`define FRWLS_BIT_DONE    0
`define FRWLS_BIT_IE      1
`define FRWLS_KEY1        8'h55
`define FRWLS_KEY2        8'haa
`define FRWLS_BLANK       14'h3fff
`define FRWLS_LATCHES     32
`define FRWLS_LAST_IDX    5'h1f
`define FRWLS_UID_LO      15'h0000
`define FRWLS_UID_HI      15'h0003
`define FRWLS_ID_LO       15'h0005
`define FRWLS_ID_HI       15'h0006
`define FRWLS_CFG_LO      15'h0007
`define FRWLS_CFG_HI      15'h000b
`define FRWLS_DIA_LO      15'h0100
`define FRWLS_DIA_HI      15'h02ff
`endif

/* rtl/frwls_pkg.sv */
// Types shared by the sequencer modules.
package frwls_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_LOAD, ST_ERASE, ST_PROG, ST_BLANK} frwls_state_t;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_KEY2} frwls_unlock_t;
  typedef enum logic [1:0] {FA_NONE, FA_READ, FA_PROG, FA_ERASE} frwls_cmd_t;
  typedef struct packed {
    logic        valid;
    frwls_cmd_t  cmd;
    logic [15:0] addr;
    logic [13:0] wdata;
  } frwls_fa_req_t;
endpackage

/* rtl/frwls_region_check.sv */
// Address permission decode for the main and auxiliary spaces.
`timescale 1ns/1ps
`include "frwls_defines.svh"
module frwls_region_check
  import frwls_pkg::*;
(
  // Address under test.
  input  wire logic        aux_i,
  input  wire logic [14:0] addr_i,
  // Permissions.
  output logic             rd_ok_o,
  output logic             wr_ok_o
);
  logic in_uid;
  logic in_ro;
  assign in_uid = (addr_i >= `FRWLS_UID_LO) && (addr_i <= `FRWLS_UID_HI);
  assign in_ro  = ((addr_i >= `FRWLS_ID_LO) && (addr_i <= `FRWLS_CFG_HI))
               || ((addr_i >= `FRWLS_DIA_LO) && (addr_i <= `FRWLS_DIA_HI));
  assign rd_ok_o = ~aux_i | in_uid | in_ro;
  assign wr_ok_o = ~aux_i | in_uid;
endmodule

/* rtl/frwls_latch_bank.sv */
// Row-aligned bank of write latches with blank restore.
`timescale 1ns/1ps
`include "frwls_defines.svh"
module frwls_latch_bank
  import frwls_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Load and blank.
  input  wire logic        load_i,
  input  wire logic [4:0]  load_idx_i,
  input  wire logic [13:0] load_data_i,
  input  wire logic        blank_i,
  // Read port.
  input  wire logic [4:0]  rd_idx_i,
  output logic [13:0]      rd_data_o
);
  logic [13:0] word_reg [`FRWLS_LATCHES];
  genvar g;
  generate
    for (g = 0; g < `FRWLS_LATCHES; g++) begin : g_lat
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i || blank_i) begin
          word_reg[g] <= `FRWLS_BLANK;
        end else if (load_i && load_idx_i == 5'(g)) begin
          word_reg[g] <= load_data_i;
        end
      end
    end
  endgenerate
  assign rd_data_o = word_reg[rd_idx_i];

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_BLANK: assert property (blank_i |=> word_reg[0] == `FRWLS_BLANK
    && word_reg[31] == `FRWLS_BLANK) else $error("latches not blank after operation");
  AST_LATCH_INDEX: assert property (load_i && !blank_i |=>
    word_reg[$past(load_idx_i)] == $past(load_data_i)) else $error("wrong latch loaded");
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the flash row write-latch sequencer.
`timescale 1ns/1ps
`include "frwls_defines.svh"
module tb_top
  import frwls_pkg::*;
;
  localparam logic [7:0] B_RD    = 8'h01;
  localparam logic [7:0] B_WR    = 8'h02;
  localparam logic [7:0] B_WE    = 8'h04;
  localparam logic [7:0] B_ERR   = 8'h08;
  localparam logic [7:0] B_LATCH = 8'h10;
  localparam logic [7:0] B_ERASE = 8'h20;
  localparam logic [7:0] B_AUX   = 8'h40;
  logic          core_clk_i       = 1'b0;
  logic          rstn_i           = 1'b0;
  logic [4:0]    avs_address_i    = 5'h00;
  logic          avs_read_i       = 1'b0;
  logic          avs_write_i      = 1'b0;
  logic [31:0]   avs_writedata_i  = 32'h0;
  logic [3:0]    avs_byteenable_i = 4'hf;
  logic [31:0]   avs_readdata_o;
  logic          avs_waitrequest_o;
  frwls_fa_req_t fa_req_o;
  logic          fa_ack_i         = 1'b0;
  logic [13:0]   fa_rdata_i       = 14'h0;
  logic          irq_o;
  logic          ws               = 1'b1;
  logic          rd_pend          = 1'b0;
  logic [1:0]    dly              = 2'h1;
  logic [13:0]   rdw              = 14'h0;
  logic [13:0]   lat [32];
  logic [32:0]   rdq [$];
  logic [32:0]   faq [$];
  logic [32:0]   fe;
  logic [32:0]   re;
  logic [31:0]   rv;
  logic [16:0]   etab [5] = '{17'h1_0123, 17'h1_8002, 17'h0_8100, 17'h0_8007, 17'h0_8005};
  logic [16:0]   rtab [7] = '{17'h1_8005, 17'h0_8004, 17'h1_8100, 17'h0_8300,
                              17'h1_82ff, 17'h0_800c, 17'h1_1a47};
  integer        seed             = 32'hc1ef;
  int            miscompares      = 0;
  int            n_checks         = 0;
  int            cyc              = 0;

  frwls_top DUT (
    .core_clk_i       (core_clk_i),
    .rstn_i           (rstn_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .fa_req_o         (fa_req_o),
    .fa_ack_i         (fa_ack_i),
    .fa_rdata_i       (fa_rdata_i),
    .irq_o            (irq_o)
  );

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waitrequest is registered, so its value at the falling edge is what the next rise sees.
  always @(negedge core_clk_i) begin
    ws <= avs_waitrequest_o;
    if (rd_pend && rdq.size() > 0) begin
      re = rdq.pop_front();
      if (re[32])
        cmp(avs_readdata_o, re[31:0]);
    end
  end

  // Flash array stand-in: acks after one or three cycles, read word only with the ack.
  always @(posedge core_clk_i) begin
    rd_pend <= avs_read_i && (ws === 1'b0);
    if (fa_ack_i) begin
      fa_ack_i   <= 1'b0;
      fa_rdata_i <= ~rdw;
      dly        <= 2'($random(seed)) | 2'h1;
    end else if (fa_req_o.valid === 1'b1) begin
      if (dly == 2'h1) begin
        fa_ack_i   <= 1'b1;
        fa_rdata_i <= rdw;
      end
      dly <= dly - 2'h1;
    end
    if (fa_req_o.valid === 1'b1 && fa_ack_i) begin
      if (faq.size() == 0)
        cmp({fa_req_o.cmd, fa_req_o.addr, fa_req_o.wdata}, 32'h0);
      else begin
        fe = faq.pop_front();
        cmp({fa_req_o.cmd, fa_req_o.addr, fe[32] ? fa_req_o.wdata : 14'h0}, fe[31:0]);
      end
    end
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [32:0] ex);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= {24'h0, d};
    if (!wr)
      rdq.push_back(ex);
    do begin
      @(posedge core_clk_i);
      n++;
    end while (ws !== 1'b0 && n < 100);
    if (n >= 100)
      miscompares++;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(negedge core_clk_i);
    rv = avs_readdata_o;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h0, {1'b1, exp});
  endtask

  task automatic adr(input logic [14:0] a);
    wr(`FRWLS_OFS_ADR_LO, a[7:0]);
    wr(`FRWLS_OFS_ADR_HI, {1'b0, a[14:8]});
  endtask

  task automatic start(input logic [7:0] ctl);
    wr(`FRWLS_OFS_UNLOCK, `FRWLS_KEY1);
    wr(`FRWLS_OFS_UNLOCK, `FRWLS_KEY2);
    wr(`FRWLS_OFS_CTRL_A, ctl | B_WR | B_WE);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, `FRWLS_OFS_CTRL_A, 8'h0, 33'h0);
      n++;
    end while ((rv[1] | rv[0]) !== 1'b0 && n < 300);
    if (n >= 300)
      miscompares++;
  endtask

  task automatic blank();
    for (int i = 0; i < 32; i++)
      lat[i] = `FRWLS_BLANK;
  endtask

  // Loads one word; the last one of a row starts programming with every latch expected.
  task automatic word(input logic [14:0] a, input logic last);
    logic [13:0] d;
    d = 14'($random(seed));
    adr(a);
    wr(`FRWLS_OFS_DAT_LO, d[7:0]);
    wr(`FRWLS_OFS_DAT_HI, {2'h0, d[13:8]});
    lat[a[4:0]] = d;
    if (last) begin
      for (int i = 0; i < 32; i++)
        faq.push_back({1'b1, FA_PROG, 1'b0, a[14:5], 5'(i), lat[i]});
      blank();
    end
    start(last ? 8'h00 : B_LATCH);
    if (last) begin
      rd(`FRWLS_OFS_CTRL_A, {24'h0, B_WR | B_WE});
      idle();
    end
  endtask

  initial begin
    logic        ok;
    logic [13:0] ex;
    logic [7:0]  reg_aux;
    blank();
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(`FRWLS_OFS_CTRL_A, 32'h0);
    rd(`FRWLS_OFS_UNLOCK, 32'h0);
    rd(`FRWLS_OFS_ADR_LO, 32'h0);
    rd(`FRWLS_OFS_CTRL_B, 32'h0);
    wr(5'h1c, 8'hff);
    rd(5'h1c, 32'h0);
    wr(`FRWLS_OFS_CTRL_B, 8'h02);
    word(15'h1a40, 1'b0);
    word(15'h1a47, 1'b0);
    word(15'h1a5f, 1'b1);
    rd(`FRWLS_OFS_CTRL_B, 32'h3);
    cmp({31'h0, irq_o}, 32'h1);
    wr(`FRWLS_OFS_CTRL_B, 8'h02);
    rd(`FRWLS_OFS_CTRL_B, 32'h2);
    cmp({31'h0, irq_o}, 32'h0);
    word(15'h1a63, 1'b1);
    adr(15'h1a44);
    wr(`FRWLS_OFS_UNLOCK, `FRWLS_KEY1);
    wr(`FRWLS_OFS_ADR_LO, 8'h44);
    wr(`FRWLS_OFS_UNLOCK, `FRWLS_KEY2);
    rd(`FRWLS_OFS_CTRL_A, {24'h0, B_ERR | B_WE});
    wr(`FRWLS_OFS_CTRL_A, B_WR | B_WE | B_LATCH);
    rd(`FRWLS_OFS_CTRL_A, {24'h0, B_WE | B_LATCH});
    wr(`FRWLS_OFS_CTRL_A, B_WE);
    rd(`FRWLS_OFS_CTRL_A, {24'h0, B_WE});
    word(15'h0049, 1'b0);
    foreach (etab[k]) begin
      ok      = etab[k][16];
      reg_aux = etab[k][15] ? B_AUX : 8'h00;
      if (ok)
        faq.push_back({1'b0, FA_ERASE, etab[k][15:5], 5'h0, 14'h0});
      adr(etab[k][14:0]);
      start(B_ERASE | reg_aux);
      idle();
      rd(`FRWLS_OFS_CTRL_A, {24'h0, B_WE | B_ERASE | reg_aux | (ok ? 8'h0 : B_ERR)});
      wr(`FRWLS_OFS_CTRL_A, B_WE);
      if (ok)
        blank();
    end
    word(15'h1a5f, 1'b1);
    foreach (rtab[k]) begin
      ok      = rtab[k][16];
      reg_aux = rtab[k][15] ? B_AUX : 8'h00;
      rdw     = 14'($random(seed));
      ex      = ok ? rdw : 14'h0;
      if (ok)
        faq.push_back({1'b0, FA_READ, rtab[k][15:0], 14'h0});
      adr(rtab[k][14:0]);
      wr(`FRWLS_OFS_CTRL_A, B_RD | reg_aux);
      idle();
      rd(`FRWLS_OFS_DAT_LO, {24'h0, ex[7:0]});
      rd(`FRWLS_OFS_DAT_HI, {26'h0, ex[13:8]});
    end
    cmp(32'(faq.size()), 32'h0);
    end_of_test();
  end
endmodule
